//--- rtl/i2c_slave_addr_status.sv
/*
  Byte-oriented I2C slave with own-address compare, pin pair select,
  data hold per speed and Stop interrupt,
  paced by firmware through Avalon-MM.
  Assumes pads resolved outside, one clk domain and a master that
  honours clock stretching.
*/
`include "i2c_slave_params.svh"

// Operation
// R01: hw match on: own address acked automatically.
// R02: hw match on: mismatch NAKed, idle till next Start.
// R03: hw match on: address flag bit 3 stays clear.
// R04: hw match off: address flag, stall, address in data.
// R05: software must set main enable bit 0 for the feature.
// R06: seven-bit own address in bits 6:0, used only with hw match.
// R07: address matching is independent of any buffering mode.
// R08: pin select bit 6 picks pins 5/7 when clear, 0/1 when set.
// R09: Stop interrupt enable bit 4 raises interrupt on Stop.
// R10: speed field bits 3:2: 100k, 400k, 50k; code 11 reserved.
// R11: status/control bits held at reset until enable is set.
// R12: bus error bit 7 set on misplaced Start/Stop; firmware zero clears.
// R13: Stop flag bit 5 set on Stop; stays until firmware writes zero.
// R14: ack-out bit 4 zero means NACK; cleared on every byte complete.
// R15: byte complete after eight received or eight sent plus ack; Start clears.
// R16: last-ack bit holds receiver ninth bit: zero ACK, one NAK.
// R17: address flag set on address byte, cleared only by firmware zero.
// R18: data register reads received byte, write loads byte to send.
// R19: SCL held low while stalled, released after firmware service.
module i2c_slave_addr_status
  import i2c_slave_pkg::*;
(
  // system
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // avalon-mm register slave
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // pin pair A (port-1 pins 5 and 7)
  input  wire logic        sclPairAIn,
  input  wire logic        sdaPairAIn,
  output logic             sclPairAOut,
  output logic             sdaPairAOut,
  output logic             sclPairAOeN,
  output logic             sdaPairAOeN,
  // pin pair B (port-1 pins 0 and 1)
  input  wire logic        sclPairBIn,
  input  wire logic        sdaPairBIn,
  output logic             sclPairBOut,
  output logic             sdaPairBOut,
  output logic             sclPairBOeN,
  output logic             sdaPairBOeN,
  // interrupt
  output logic             irq
);

  // configuration
  logic                hwMatchEn;
  logic [6:0]          ownAddr;
  logic                cfgEnable;
  logic [1:0]          cfgSpeed;
  logic                cfgStopIe;
  logic                cfgPinSel;
  // status/control bits
  logic                byteDone;
  logic                lastAckBit;
  logic                transmit;
  logic                addrFlag;
  logic                ackOut;
  logic                stopSeen;
  logic                busErr;
  // data port and engine
  logic [7:0]          dataReg;
  state_t              state;
  logic [3:0]          bitCnt;
  logic [7:0]          shifter;
  logic                isAddr;
  logic                hwAddr;
  logic                rxDir;
  logic                ackVal;
  logic                phaseAck;
  logic [`HOLD_W-1:0]  holdCnt;
  logic [`HOLD_W-1:0]  holdCycles;
  logic                driveLevel;
  // interrupts
  logic [2:0]          irqStatus;
  logic [2:0]          irqEnable;
  // pins
  logic [3:0]          pinMeta;
  logic [3:0]          pinSync;
  logic                sclPrev;
  logic                sdaPrev;
  logic                sclNow;
  logic                sdaNow;
  logic                sclRise;
  logic                sclFall;
  logic                startDet;
  logic                stopDet;
  // decode and events
  logic [7:0]          regIdx;
  logic                wrEn;
  logic                wrScr;
  logic [7:0]          rdMux;
  logic                hwEn;
  logic                recvDone;
  logic                addrHit;
  logic                midByte;
  logic                evByte;
  logic                evAddr;
  logic                evErr;
  logic                evStop;
  logic                wantSdaLow;
  logic                sdaLow;
  logic                next_sdaLow;
  logic                next_sclLow;

  // decode; a write lands when waitrequest is low
  assign regIdx = address[9:2];
  assign wrEn   = write & ~waitrequest;
  assign wrScr  = wrEn & (regIdx == `IDX_SCR);
  assign hwEn   = hwMatchEn & cfgEnable; // R05

  // two-flop pad synchronisers, idle high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta <= 4'hF;
      pinSync <= 4'hF;
    end else if (ce) begin
      pinMeta <= {sdaPairBIn, sclPairBIn, sdaPairAIn, sclPairAIn};
      pinSync <= pinMeta;
    end
  end

  // selected pair and its history
  assign sclNow = cfgPinSel ? pinSync[2] : pinSync[0]; // R08
  assign sdaNow = cfgPinSel ? pinSync[3] : pinSync[1]; // R08

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else if (ce) begin
      sclPrev <= sclNow;
      sdaPrev <= sdaNow;
    end
  end

  // bus conditions
  assign sclRise  = sclNow & ~sclPrev;
  assign sclFall  = ~sclNow & sclPrev;
  assign startDet = cfgEnable & sclNow & sclPrev & sdaPrev & ~sdaNow;
  assign stopDet  = cfgEnable & sclNow & sclPrev & ~sdaPrev & sdaNow;

  // engine events
  assign recvDone = (state == stRecv) & (bitCnt == `BITS_PER_BYTE) & sclFall;
  assign addrHit  = shifter[7:1] == ownAddr; // R06
  // a Stop or repeated Start follows one SCL rise: legal until the second
  assign midByte  = ((state == stRecv) & (bitCnt > 4'h1))
                  | (state == stSend) | (state == stSendAck)
                  | (state == stAck);
  assign evErr    = (startDet | stopDet) & midByte; // R12
  assign evStop   = stopDet;
  assign evAddr   = recvDone & isAddr & ~hwEn; // R03 R04 R17
  assign evByte   = (recvDone & ~(isAddr & hwEn))
                  | ((state == stAck) & sclFall & hwAddr & rxDir & ackVal)
                  | ((state == stSendAck) & sclFall); // R15

  // byte engine; behaves alike in every buffering mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state    <= stIdle;
      bitCnt   <= 4'h0;
      shifter  <= `RST_BYTE;
      isAddr   <= 1'b0;
      hwAddr   <= 1'b0;
      rxDir    <= 1'b0;
      ackVal   <= 1'b0;
      phaseAck <= 1'b0;
    end else if (ce) begin
      if (!cfgEnable) begin
        state <= stIdle;
      end else if (startDet) begin
        state  <= stRecv;
        bitCnt <= 4'h0;
        isAddr <= 1'b1;
        hwAddr <= 1'b0;
      end else if (stopDet) begin
        state <= stIdle;
      end else begin
        unique case (state)
          stIdle, stSkip: begin
          end
          stRecv: begin
            if (sclRise) begin
              shifter <= {shifter[6:0], sdaNow};
              bitCnt  <= bitCnt + 4'h1;
            end else if (recvDone) begin
              rxDir  <= shifter[0];
              hwAddr <= isAddr & hwEn;
              if (isAddr && hwEn) begin // R07
                if (addrHit) begin
                  state  <= stAck; // R01
                  ackVal <= 1'b1;
                end else begin
                  state <= stIdle; // R02
                end
              end else begin
                state    <= stStall; // R04
                phaseAck <= 1'b1;
              end
            end
          end
          stStall: begin
            if (!byteDone) begin // R19
              if (phaseAck) begin
                state  <= stAck;
                ackVal <= ackOut; // R14
              end else begin
                state   <= stSend;
                shifter <= dataReg;
                bitCnt  <= 4'h0;
              end
            end
          end
          stAck: begin
            if (sclFall) begin
              isAddr <= 1'b0;
              hwAddr <= 1'b0;
              bitCnt <= 4'h0;
              if (!ackVal) begin
                state <= stSkip;
              end else if (hwAddr) begin
                state    <= rxDir ? stStall : stRecv;
                phaseAck <= 1'b0;
              end else if (transmit) begin
                state   <= stSend;
                shifter <= dataReg;
              end else begin
                state <= stRecv;
              end
            end
          end
          stSend: begin
            if (sclRise) begin
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall) begin
              shifter <= {shifter[6:0], 1'b1};
              if (bitCnt == `BITS_PER_BYTE) begin
                state <= stSendAck;
              end
            end
          end
          stSendAck: begin
            if (sclFall) begin
              state    <= lastAckBit ? stSkip : stStall;
              phaseAck <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // hold per speed; reserved code acts as 100 kHz
  always_comb begin
    case (cfgSpeed)
      `SPEED_100K: holdCycles = `CYC(`T_HOLD_100K_NS); // R10
      `SPEED_400K: holdCycles = `CYC(`T_HOLD_400K_NS); // R10
      `SPEED_50K:  holdCycles = `CYC(`T_HOLD_50K_NS); // R10
      default:     holdCycles = `CYC(`T_HOLD_100K_NS);
    endcase
  end

  // hold timer restarts on each SCL fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      holdCnt <= '0;
    end else if (ce) begin
      if (sclFall) begin
        holdCnt <= holdCycles;
      end else if (holdCnt != '0) begin
        holdCnt <= holdCnt - `HOLD_W'(1);
      end
    end
  end

  // pad drive: SDA after the hold, SCL stretches
  assign wantSdaLow  = cfgEnable & (((state == stAck) & ackVal)
                     | ((state == stSend) & ~shifter[7]));
  assign sdaLow      = cfgPinSel ? ~sdaPairBOeN : ~sdaPairAOeN;
  assign next_sdaLow = (holdCnt == '0) ? wantSdaLow : sdaLow;
  assign next_sclLow = cfgEnable & ((state == stStall)
                     | (next_sdaLow != wantSdaLow)); // R19

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclPairAOeN <= 1'b1;
      sdaPairAOeN <= 1'b1;
      sclPairBOeN <= 1'b1;
      sdaPairBOeN <= 1'b1;
    end else if (ce) begin
      sclPairAOeN <= ~(~cfgPinSel & next_sclLow); // R08
      sdaPairAOeN <= ~(~cfgPinSel & next_sdaLow);
      sclPairBOeN <= ~(cfgPinSel & next_sclLow); // R08
      sdaPairBOeN <= ~(cfgPinSel & next_sdaLow);
    end
  end

  // open-drain pads only ever pull low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      driveLevel <= 1'b0;
    end else if (ce) begin
      driveLevel <= 1'b0;
    end
  end
  assign sclPairAOut = driveLevel;
  assign sdaPairAOut = driveLevel;
  assign sclPairBOut = driveLevel;
  assign sdaPairBOut = driveLevel;

  // configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hwMatchEn <= 1'b0;
      ownAddr   <= 7'h00;
      cfgEnable <= 1'b0;
      cfgSpeed  <= 2'h0;
      cfgStopIe <= 1'b0;
      cfgPinSel <= 1'b0;
      irqEnable <= `RST_IRQ;
    end else if (ce && wrEn) begin
      unique case (regIdx)
        `IDX_EXT_CFG:  hwMatchEn <= writedata[`XCFG_HW_MATCH];
        `IDX_OWN_ADDR: ownAddr <= writedata[6:0]; // R06
        `IDX_CFG: begin
          cfgEnable <= writedata[`CFG_ENABLE];
          cfgSpeed  <= writedata[`CFG_SPEED_HI:`CFG_SPEED_LO]; // R10
          cfgStopIe <= writedata[`CFG_STOP_IRQ_ENABLE];
          cfgPinSel <= writedata[`CFG_PIN_SEL];
        end
        `IDX_IRQ_EN:   irqEnable <= writedata[2:0];
        default: begin
        end
      endcase
    end
  end

  // status flags; clear while disabled; bus events beat firmware writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      byteDone   <= 1'b0;
      lastAckBit <= 1'b0;
      transmit   <= 1'b0;
      addrFlag   <= 1'b0;
      ackOut     <= 1'b0;
      stopSeen   <= 1'b0;
      busErr     <= 1'b0;
    end else if (ce) begin
      if (!cfgEnable) begin // R11
        byteDone   <= 1'b0;
        lastAckBit <= 1'b0;
        transmit   <= 1'b0;
        addrFlag   <= 1'b0;
        ackOut     <= 1'b0;
        stopSeen   <= 1'b0;
        busErr     <= 1'b0;
      end else begin
        if (evByte) begin
          byteDone <= 1'b1; // R15
        end else if (startDet) begin
          byteDone <= 1'b0; // R15
        end else if (wrScr && !writedata[`SCR_BYTE_DONE]) begin
          byteDone <= 1'b0;
        end
        if (startDet) begin
          lastAckBit <= 1'b0;
        end else if (state == stSendAck && sclRise) begin
          lastAckBit <= sdaNow; // R16
        end
        if (startDet) begin
          transmit <= 1'b0;
        end else if (wrScr) begin
          transmit <= writedata[`SCR_TRANSMIT];
        end
        if (evAddr) begin
          addrFlag <= 1'b1; // R17
        end else if (wrScr && !writedata[`SCR_ADDR]) begin
          addrFlag <= 1'b0; // R17
        end
        if (evByte) begin
          ackOut <= 1'b0; // R14
        end else if (wrScr) begin
          ackOut <= writedata[`SCR_ACK_OUT];
        end
        if (evStop) begin
          stopSeen <= 1'b1; // R13
        end else if (wrScr && !writedata[`SCR_STOP]) begin
          stopSeen <= 1'b0; // R13
        end
        if (evErr) begin
          busErr <= 1'b1; // R12
        end else if (wrScr && !writedata[`SCR_BUS_ERR]) begin
          busErr <= 1'b0; // R12
        end
      end
    end
  end

  // data port: received byte in, firmware byte out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dataReg <= `RST_BYTE;
    end else if (ce) begin
      if (recvDone) begin
        dataReg <= shifter; // R18 R04
      end else if (wrEn && regIdx == `IDX_DATA) begin
        dataReg <= writedata[7:0]; // R18
      end
    end
  end

  // sticky interrupt status, write-one clear, set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStatus <= `RST_IRQ;
      irq       <= 1'b0;
    end else if (ce) begin
      for (int i = 0; i < 3; i++) begin
        if (wrEn && regIdx == `IDX_IRQ_CLR && writedata[i]) begin
          irqStatus[i] <= 1'b0;
        end
      end
      if (evByte) irqStatus[`IRQ_BYTE] <= 1'b1;
      if (evStop && cfgStopIe) irqStatus[`IRQ_STOP] <= 1'b1; // R09
      if (evErr) irqStatus[`IRQ_ERR] <= 1'b1;
      irq <= |(irqStatus & irqEnable);
    end
  end

  // read mux; reserved and unmapped bits read zero
  always_comb begin
    case (regIdx)
      `IDX_EXT_CFG:  rdMux = {7'h00, hwMatchEn};
      `IDX_OWN_ADDR: rdMux = {1'b0, ownAddr};
      `IDX_CFG:      rdMux = {1'b0, cfgPinSel, 1'b0, cfgStopIe, cfgSpeed,
                              1'b0, cfgEnable};
      `IDX_SCR:      rdMux = {busErr, 1'b0, stopSeen, ackOut, addrFlag,
                              transmit, lastAckBit, byteDone};
      `IDX_DATA:     rdMux = dataReg;
      `IDX_IRQ_STAT: rdMux = {5'h00, irqStatus};
      `IDX_IRQ_EN:   rdMux = {5'h00, irqEnable};
      default:       rdMux = 8'h00;
    endcase
  end

  // avalon answer after one wait cycle, low for one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else if (ce) begin
      if ((read || write) && waitrequest) begin
        waitrequest <= 1'b0;
        readdata    <= {24'h00_0000, rdMux};
      end else begin
        waitrequest <= 1'b1;
      end
    end
  end

endmodule // i2c_slave_addr_status

//--- rtl/i2c_slave_params.svh
/*
  Offsets, fields, resets and timing counts of the I2C slave. Assumes
  a 40 MHz clock and byte address = 4 * word index.
*/
`ifndef I2C_SLAVE_PARAMS_SVH
`define I2C_SLAVE_PARAMS_SVH

// system clock rate
`define CLK_MHZ        40

// register word indices
`define IDX_EXT_CFG    8'hC8
`define IDX_OWN_ADDR   8'hCA
`define IDX_CFG        8'hD6
`define IDX_SCR        8'hD7
`define IDX_DATA       8'hD8
`define IDX_IRQ_STAT   8'hE0
`define IDX_IRQ_EN     8'hE1
`define IDX_IRQ_CLR    8'hE2

// reset values
`define RST_BYTE       8'h00
`define RST_IRQ        3'h0

// slave_ext_config fields
`define XCFG_HW_MATCH  0
// slave_config fields
`define CFG_ENABLE     0
`define CFG_SPEED_LO   2
`define CFG_SPEED_HI   3
`define CFG_STOP_IRQ_ENABLE    4
`define CFG_PIN_SEL    6
// slave_status_control fields
`define SCR_BYTE_DONE  0
`define SCR_LRB        1
`define SCR_TRANSMIT   2
`define SCR_ADDR       3
`define SCR_ACK_OUT    4
`define SCR_STOP       5
`define SCR_BUS_ERR    7
// irq status, enable, clear fields
`define IRQ_BYTE       0
`define IRQ_STOP       1
`define IRQ_ERR        2

// bus speed codes
`define SPEED_100K     2'h0
`define SPEED_400K     2'h1
`define SPEED_50K      2'h2

// data hold after SCL fall per speed, in ns; CYC turns it into cycles
`define HOLD_W         5
`define T_HOLD_100K_NS 300
`define T_HOLD_400K_NS 100
`define T_HOLD_50K_NS  600
`define CYC(ns)        5'(((ns) * `CLK_MHZ + 999) / 1000)

// byte length on the wire
`define BITS_PER_BYTE  4'h8

`endif

//--- rtl/i2c_slave_pkg.sv
/*
  Types of the I2C slave. Assumes nothing.
*/
package i2c_slave_pkg;
  // byte engine states
  typedef enum logic [2:0] {
    stIdle,
    stRecv,
    stStall,
    stAck,
    stSend,
    stSendAck,
    stSkip
  } state_t;
endpackage

//--- sim/i2c_slave_properties.sv
/*
  Port checks of the i2c slave. Assumes one clk domain, ce high.
*/
`include "i2c_slave_params.svh"

module i2c_slave_checker
  import i2c_slave_pkg::*;
(
  // system and register bus
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [9:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // pads and interrupt
  input wire logic        sclPairAIn,
  input wire logic        sclPairAOeN,
  input wire logic        sdaPairAOeN,
  input wire logic        sclPairBOeN,
  input wire logic        sdaPairBOeN,
  input wire logic        irq
);
  logic [7:0] cfg;
  logic [7:0] irqEn;
  logic       hwMatch;
  logic [7:0] low;
  logic [7:0] held;
  logic [7:0] age;
  wire  [7:0] idx  = address[9:2];
  wire        wrOk = write && !waitrequest;
  wire  [7:0] hold = (cfg[3:2] == `SPEED_400K) ? 8'h04 :
                     (cfg[3:2] == `SPEED_50K) ? 8'h18 : 8'h0C;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // firmware settings
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg     <= 8'h00;
      irqEn   <= 8'h00;
      hwMatch <= 1'b0;
    end else if (wrOk) begin
      if (idx == `IDX_CFG) cfg <= writedata[7:0];
      if (idx == `IDX_IRQ_EN) irqEn <= writedata[7:0];
      if (idx == `IDX_EXT_CFG) hwMatch <= writedata[0];
    end
  end

  // pad low, stretch, status write age
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low  <= 8'h00;
      held <= 8'h00;
      age  <= 8'hFF;
    end else begin
      low  <= sclPairAIn ? 8'h00 : low + {7'h00, ~&low};
      held <= sclPairAOeN ? 8'h00 : held + {7'h00, ~&held};
      age  <= (wrOk && idx == `IDX_SCR) ? 8'h00 : age + {7'h00, ~&age};
    end
  end

  sequence sRead;
    read && !waitrequest;
  endsequence
  sequence sAsk;
    $rose(read || write);
  endsequence

  a_one_wait: assert property (sAsk |=> !waitrequest)
    else $error("no answer after one wait");
  a_single_accept: assert property (!waitrequest |=> waitrequest)
    else $error("accept too long");
  a_unmapped_zero: assert property (sRead ##0 idx == 8'hFF |-> readdata == 0)
    else $error("unmapped read nonzero");
  a_upper_zero: assert property (sRead |-> readdata[31:8] == 24'h0)
    else $error("upper bits nonzero");
  a_status_held: assert property (sRead ##0 (idx == `IDX_SCR &&
      !cfg[0] && !$past(cfg[0])) |-> readdata[7:0] == 8'h00)
    else $error("status not held");
  a_no_addr_flag: assert property (sRead ##0 (idx == `IDX_SCR && hwMatch)
      |-> !readdata[`SCR_ADDR])
    else $error("address flag under compare");
  a_sda_hold: assert property ($changed(sdaPairAOeN) && !cfg[6]
      |-> low >= hold)
    else $error("data moved in hold");
  a_stretch_release: assert property ($rose(sclPairAOeN) &&
      $past(held) > 8'd50 |-> age < 8'd40)
    else $error("unserviced release");
  a_irq_masked: assert property (irqEn == 8'h00 &&
      $past(irqEn) == 8'h00 |-> !irq)
    else $error("masked irq raised");
  a_pair_a_idle: assert property (cfg[6] && $past(cfg[6])
      |-> sclPairAOeN && sdaPairAOeN)
    else $error("pair A driven");
  a_pair_b_idle: assert property (!cfg[6] && !$past(cfg[6])
      |-> sclPairBOeN && sdaPairBOeN)
    else $error("pair B driven");
endmodule // i2c_slave_checker

bind i2c_slave_addr_status i2c_slave_checker chk (
  .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .sclPairAIn(sclPairAIn), .sclPairAOeN(sclPairAOeN),
  .sdaPairAOeN(sdaPairAOeN), .sclPairBOeN(sclPairBOeN),
  .sdaPairBOeN(sdaPairBOeN), .irq(irq)
);

//--- sim/i2c_master_model.sv
/*
  I2C master model, 200 ns bits, honours stretching.
  Assumes pulled-up open-drain wires.
*/
module i2c_master_model (
  // clock
  input wire logic clk,
  // resolved wires
  input wire logic sclW,
  input wire logic sdaW,
  // drive, high = released
  output logic     sclD,
  output logic     sdaD
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclD = 1'b1;
    sdaD = 1'b1;
  end
  // quarter bit time
  task automatic q;
    repeat (2) @(posedge clk);
  endtask
  // wait out clock stretching
  task automatic hi;
    int n;
    n = 0;
    while (sclW !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
  endtask
  // one bit: set while SCL low, sampled high
  task automatic bitx(input logic b, output logic r);
    sdaD <= b;
    q;
    sclD <= 1'b1;
    q;
    hi;
    r = sdaW;
    q;
    sclD <= 1'b0;
    q;
  endtask
  task automatic start;
    sdaD <= 1'b1;
    q;
    sclD <= 1'b1;
    q;
    hi;
    sdaD <= 1'b0;
    q;
    sclD <= 1'b0;
    q;
  endtask
  task automatic stop;
    sdaD <= 1'b0;
    q;
    sclD <= 1'b1;
    q;
    hi;
    sdaD <= 1'b1;
    q;
  endtask
  // byte out, then slave ack
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, ack);
  endtask
  // byte in, then our ack
  task automatic get(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(nak, r);
  endtask
endmodule // i2c_master_model

//--- sim/tb_top.sv
/*
  Bench of the i2c slave: Avalon firmware, master model on the pair pinSel picks.
  Assumes the bound checker and pull-ups.
*/
`include "i2c_slave_params.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  address = 10'h000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic        pinSel = 1'b0;
  logic [31:0] readdata;
  logic        waitrequest, irq, sclD, sdaD, ack;
  logic        sclPairAOeN, sdaPairAOeN, sclPairBOeN, sdaPairBOeN;
  logic [6:0]  oa;
  logic [7:0]  v, tx;
  int          mismatches = 0;
  int          n_compared = 0;
  int          seed = 76;
  int          cyc = 0;
  logic [7:0]  regs [9] = '{`IDX_EXT_CFG, `IDX_OWN_ADDR, `IDX_CFG,
    `IDX_SCR, `IDX_DATA, `IDX_IRQ_STAT, `IDX_IRQ_EN, `IDX_IRQ_CLR, 8'hFF};
  wire sclW = sclD & (pinSel ? sclPairBOeN : sclPairAOeN);
  wire sdaW = sdaD & (pinSel ? sdaPairBOeN : sdaPairAOeN);

  always #12.5 clk = ~clk;

  i2c_slave_addr_status dut (
    .clk(clk), .rst(rst), .ce(1'b1), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq),
    .sclPairAIn(pinSel ? sclPairAOeN : sclW),
    .sdaPairAIn(pinSel ? sdaPairAOeN : sdaW),
    .sclPairBIn(pinSel ? sclW : sclPairBOeN),
    .sdaPairBIn(pinSel ? sdaW : sdaPairBOeN),
    .sclPairAOut(), .sdaPairAOut(), .sclPairBOut(), .sdaPairBOut(),
    .sclPairAOeN(sclPairAOeN), .sdaPairAOeN(sdaPairAOeN),
    .sclPairBOeN(sclPairBOeN), .sdaPairBOeN(sdaPairBOeN)
  );
  i2c_master_model m (
    .clk(clk), .sclW(sclW), .sdaW(sdaW), .sclD(sclD), .sdaD(sdaD)
  );

  // one access, held until waitrequest low
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk);
    address   <= {idx, 2'b00};
    read      <= ~wr;
    write     <= wr;
    writedata <= {24'h0, wd};
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] r;
    bus(1'b1, idx, wd, r);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    bus(1'b0, idx, 8'h00, r);
    chk(r, exp);
  endtask
  task automatic waitIrq;
    do @(posedge clk); while (irq !== 1'b1);
  endtask
  // status image from stop, addr, tx, lrb, byte done
  function automatic logic [7:0] scrOf(input logic [4:0] f);
    return {2'b00, f[4], 1'b0, f[3:0]};
  endfunction
  // firmware answer to a stalled byte after a random delay
  task automatic svc(input logic [7:0] scr, input logic [7:0] dat,
                     input logic [7:0] reply, input logic doTx);
    waitIrq;
    repeat (60 + ($random(seed) & 31)) @(posedge clk);
    rdc(`IDX_SCR, scr);
    if (doTx) wr(`IDX_DATA, tx);
    else rdc(`IDX_DATA, dat);
    wr(`IDX_IRQ_CLR, 8'h07);
    wr(`IDX_SCR, reply);
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      mismatches++;
      final_report;
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // reset values, status held while disabled
    foreach (regs[i]) rdc(regs[i], 8'h00);
    wr(`IDX_SCR, 8'h14);
    rdc(`IDX_SCR, 8'h00);
    oa = 7'($random(seed));
    tx = 8'($random(seed));
    wr(`IDX_OWN_ADDR, {1'b0, oa});
    rdc(`IDX_OWN_ADDR, {1'b0, oa});
    wr(`IDX_IRQ_EN, 8'h07);
    wr(`IDX_CFG, 8'h01);
    // firmware compare, then a refused byte
    fork
      begin
        m.start;
        m.put({oa, 1'b0}, ack);
        chk(8'(ack), 8'h00);
        m.put(tx, ack);
        chk(8'(ack), 8'h01);
        m.stop;
      end
      begin
        svc(scrOf(5'h09), {oa, 1'b0}, 8'h10, 1'b0);
        svc(scrOf(5'h01), tx, 8'h00, 1'b0);
      end
    join
    rdc(`IDX_SCR, scrOf(5'h10));
    rdc(`IDX_IRQ_STAT, 8'h00);
    wr(`IDX_SCR, 8'h00);
    // hw compare at each speed, stop irq
    wr(`IDX_EXT_CFG, 8'h01);
    for (int s = 0; s < 4; s++) begin
      wr(`IDX_CFG, 8'h11 | 8'(s << 2));
      m.start;
      m.put({oa, 1'b0}, ack);
      chk(8'(ack), 8'h00);
      m.stop;
      waitIrq;
      rdc(`IDX_SCR, scrOf(5'h10));
      wr(`IDX_IRQ_CLR, 8'h07);
      wr(`IDX_SCR, 8'h00);
    end
    // foreign address; irq masked, unmasked, cleared
    wr(`IDX_IRQ_EN, 8'h00);
    m.start;
    m.put({oa ^ 7'h01, 1'b0}, ack);
    chk(8'(ack), 8'h01);
    m.put(tx, ack);
    chk(8'(ack), 8'h01);
    m.stop;
    rdc(`IDX_IRQ_STAT, 8'h02);
    chk(8'(irq), 8'h00);
    wr(`IDX_IRQ_EN, 8'h07);
    waitIrq;
    wr(`IDX_IRQ_CLR, 8'h02);
    rdc(`IDX_IRQ_STAT, 8'h00);
    chk(8'(irq), 8'h00);
    wr(`IDX_SCR, 8'h00);
    // slave sends, master refuses
    tx = 8'($random(seed));
    m.start;
    m.put({oa, 1'b1}, ack);
    chk(8'(ack), 8'h00);
    fork
      m.get(1'b1, v);
      svc(scrOf(5'h01), 8'h00, 8'h14, 1'b1);
    join
    chk(v, tx);
    waitIrq;
    rdc(`IDX_SCR, scrOf(5'h07));
    m.stop;
    wr(`IDX_IRQ_CLR, 8'h07);
    // mid-byte stop; error survives a write of one
    m.start;
    repeat (3) m.bitx(1'b0, ack);
    m.stop;
    bus(1'b0, `IDX_SCR, 8'h00, v);
    chk(v & 8'h80, 8'h80);
    wr(`IDX_SCR, 8'h80);
    bus(1'b0, `IDX_SCR, 8'h00, v);
    chk(v & 8'h80, 8'h80);
    wr(`IDX_SCR, 8'h00);
    rdc(`IDX_SCR, 8'h00);
    // second pad pair
    wr(`IDX_CFG, 8'h41);
    pinSel <= 1'b1;
    m.start;
    m.put({oa, 1'b0}, ack);
    chk(8'(ack), 8'h00);
    m.stop;
    final_report;
  end
endmodule // tb_top
